/* core/dsaf_alu.sv */
// Arithmetic side of the DSP ALU: operand legality, add/sub family, inc/dec, flags
// Summary of operation
// - First source is an X register or accumulator; second is Y or M; any destination.
// - Paired with multiply, destination must be first X, first Y or an accumulator.
// - Select 000: flag is carry or borrow out of bit 31, guard bits ignored.
// - Select 001: flag is sign of full 40-bit result, same as negative bit.
// - Select 010: flag is set for a zero result, same as zero bit.
// - Select 011: flag is word-range overflow of the full 40-bit result, guard bits included, same as overflow bit.
// - Select 100: flag is NOT((negative XOR range) OR zero), same as greater bit.
// - Select 101: flag is NOT(negative XOR range), greater or equal.
// - Range term is set when the result exceeds the destination's representable range.
// - Negative bit follows the result sign in every select mode.
// - Zero bit is set exactly when the result is zero.
// - Overflow bit is set when the result exceeds the 32-bit word range.
// - Greater bit reports a result above zero, its sign corrected by the range term.
// - With saturation on, overflowing results clamp to maximum or minimum.
// - Integer ops use top word plus guard bits and clear the lower word.
// - Integer sources without guard bits are sign-extended; such destinations get the top word.
// - Integer ops are increment and decrement of one source from either group.
// - Integer ops run in the final stage with guard bits where present.
// - Unconditional ops update all five flags; conditional ops leave them unchanged.
// - Increment and decrement saturate too when saturation is on.
// - Sources without guard bits sign-extend; such destinations keep the lower 32 bits.
// - Add-with-carry gives carry and subtract gives borrow, whatever the select.
`timescale 1ns/100ps
`default_nettype none
module dsaf_alu #(
  parameter int GUARD_W = dsaf_pkg::GUARD_W
) (
  input wire logic sys_clk, // Core clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic op_valid, // One instruction this cycle
  input wire dsaf_pkg::dsaf_op_t op_code, // Arithmetic operation
  input wire logic use_src_two, // Single-source ops read source two
  input wire logic paired_mul, // Issued together with a multiply
  input wire logic conditional, // Instruction carries a condition
  input wire logic cond_pass, // Condition of a conditional op holds
  input wire dsaf_pkg::dsaf_reg_t src_one_sel, // Source one register index
  input wire dsaf_pkg::dsaf_reg_t src_two_sel, // Source two register index
  input wire dsaf_pkg::dsaf_reg_t dest_sel, // Destination register index
  input wire logic [dsaf_pkg::WORD_W+GUARD_W-1:0] src_one_data, // Source one contents
  input wire logic [dsaf_pkg::WORD_W+GUARD_W-1:0] src_two_data, // Source two contents
  input wire dsaf_pkg::dsaf_cs_t condition_select, // Flag mode from status register
  input wire logic sat_enable, // Saturation enable from core status
  output logic result_valid, // Write strobe to register file
  output dsaf_pkg::dsaf_reg_t result_dest, // Register to write
  output logic [dsaf_pkg::WORD_W+GUARD_W-1:0] result_data, // Value to write
  output logic illegal_operand, // Operand or opcode refused
  output logic flags_updated, // Flags changed this cycle
  output logic selected_condition_flag, // Selected condition flag
  output logic negative_flag, // Negative bit
  output logic zero_flag, // Zero bit
  output logic overflow_flag, // Overflow bit
  output logic greater_flag, // Greater-than bit
  output logic range_exceed_term // Last range term seen by the compare modes
);
  localparam int WW = dsaf_pkg::WORD_W;
  localparam int DW = WW + GUARD_W;
  localparam int IL = dsaf_pkg::INT_LSB;

  // Refused at elaboration, before any logic is built
  if (GUARD_W < 1 || GUARD_W > IL) begin
    $error("GUARD_W out of range");
  end

  function automatic logic has_guard(input dsaf_pkg::dsaf_reg_t idx);
    has_guard = (idx == dsaf_pkg::REG_FIRST_ACC) || (idx == dsaf_pkg::REG_SECOND_ACC);
  endfunction

  function automatic logic src_one_ok(input dsaf_pkg::dsaf_reg_t idx);
    src_one_ok = (idx == dsaf_pkg::REG_FIRST_X) || (idx == dsaf_pkg::REG_SECOND_X) || has_guard(idx);
  endfunction

  function automatic logic src_two_ok(input dsaf_pkg::dsaf_reg_t idx);
    src_two_ok = (idx == dsaf_pkg::REG_FIRST_Y) || (idx == dsaf_pkg::REG_SECOND_Y) ||
                 (idx == dsaf_pkg::REG_FIRST_M) || (idx == dsaf_pkg::REG_SECOND_M);
  endfunction

  function automatic logic [DW-1:0] widen(input logic [DW-1:0] data, input logic guard);
    widen = guard ? data : {{GUARD_W{data[WW-1]}}, data[WW-1:0]};
  endfunction

  dsaf_sat_if #(.DW(DW)) sif ();

  dsaf_sat_unit #(.GUARD_W(GUARD_W)) u_sat (
    .sif (sif)
  );

  // Opcode decode
  wire is_two_op = (op_code == dsaf_pkg::OP_ADD) || (op_code == dsaf_pkg::OP_SUBTRACT) ||
                   (op_code == dsaf_pkg::OP_ADD_CARRY) || (op_code == dsaf_pkg::OP_SUB_BORROW) ||
                   (op_code == dsaf_pkg::OP_COMPARE);
  wire is_int = (op_code == dsaf_pkg::OP_INCREMENT) || (op_code == dsaf_pkg::OP_DECREMENT);
  wire is_single = is_int || (op_code == dsaf_pkg::OP_COPY) || (op_code == dsaf_pkg::OP_ABS) ||
                   (op_code == dsaf_pkg::OP_NEGATE);
  wire is_clear = op_code == dsaf_pkg::OP_CLEAR;
  wire op_known = is_two_op || is_single || is_clear;

  // Operand legality
  wire needs_one = is_two_op || (is_single && !use_src_two);
  wire needs_two = is_two_op || (is_single && use_src_two);
  wire paired_ok = (dest_sel == dsaf_pkg::REG_FIRST_X) || (dest_sel == dsaf_pkg::REG_FIRST_Y) ||
                   has_guard(dest_sel);
  wire legal = op_known && (!needs_one || src_one_ok(src_one_sel)) &&
               (!needs_two || src_two_ok(src_two_sel)) && (!paired_mul || paired_ok);

  // Sources widened to the full datapath
  wire [DW-1:0] ext_one = widen(src_one_data, has_guard(src_one_sel));
  wire [DW-1:0] ext_two = widen(src_two_data, has_guard(src_two_sel));
  wire [DW-1:0] single = use_src_two ? ext_two : ext_one;
  // Top word and guard bits only; sign already replicated when no guard bits exist
  wire [DW-1:0] int_opnd = {single[DW-1:IL], {IL{1'b0}}};
  wire [DW-1:0] int_unit = {{(DW-IL-1){1'b0}}, 1'b1, {IL{1'b0}}};
  wire [DW-1:0] zero_word = {DW{1'b0}};

  wire [DW-1:0] lhs = is_two_op ? ext_one :
                      (op_code == dsaf_pkg::OP_COPY) ? single :
                      is_int ? int_opnd : zero_word;
  wire [DW-1:0] rhs = is_two_op ? ext_two :
                      ((op_code == dsaf_pkg::OP_ABS) || (op_code == dsaf_pkg::OP_NEGATE)) ? single :
                      is_int ? int_unit : zero_word;
  wire do_sub = (op_code == dsaf_pkg::OP_SUBTRACT) || (op_code == dsaf_pkg::OP_SUB_BORROW) ||
                (op_code == dsaf_pkg::OP_COMPARE) || (op_code == dsaf_pkg::OP_NEGATE) ||
                (op_code == dsaf_pkg::OP_DECREMENT) ||
                ((op_code == dsaf_pkg::OP_ABS) && single[DW-1]);
  // Stored flag acts as the carry or borrow input of the chained forms
  wire cin = (op_code == dsaf_pkg::OP_ADD_CARRY) ? selected_condition_flag :
             (op_code == dsaf_pkg::OP_SUB_BORROW) ? !selected_condition_flag : do_sub;
  wire [DW-1:0] rhs_eff = do_sub ? ~rhs : rhs;

  // Adder one bit wider than the datapath keeps the true sign for saturation
  wire [DW:0] raw = {lhs[DW-1], lhs} + {rhs_eff[DW-1], rhs_eff} + {{DW{1'b0}}, cin};
  wire [WW:0] word_sum = {1'b0, lhs[WW-1:0]} + {1'b0, rhs_eff[WW-1:0]} + {{WW{1'b0}}, cin};
  wire carry_flag = do_sub ? !word_sum[WW] : word_sum[WW];

  wire [DW-1:0] res = raw[DW-1:0];
  wire [GUARD_W:0] res_top = res[DW-1:WW-1];
  wire next_negative = res[DW-1];
  wire next_zero = res == zero_word;
  wire next_overflow = !((&res_top) || !(|res_top));
  wire next_range = sif.range_hit;
  wire next_greater = !((next_negative ^ next_range) || next_zero);
  wire next_greater_eq = !(next_negative ^ next_range);
  wire flag_forced = (op_code == dsaf_pkg::OP_ADD_CARRY) || (op_code == dsaf_pkg::OP_SUBTRACT);

  // Reserved select codes leave the flag low except for add-with-carry and subtract, which give carry or borrow
  localparam logic FLAG_LOW = 1'b0;
  wire next_selected = flag_forced ? carry_flag :
                 (condition_select == dsaf_pkg::CS_CARRY) ? carry_flag :
                 (condition_select == dsaf_pkg::CS_NEGATIVE) ? next_negative :
                 (condition_select == dsaf_pkg::CS_ZERO) ? next_zero :
                 (condition_select == dsaf_pkg::CS_OVERFLOW) ? next_overflow :
                 (condition_select == dsaf_pkg::CS_GREATER) ? next_greater :
                 (condition_select == dsaf_pkg::CS_GREATER_EQ) ? next_greater_eq : FLAG_LOW;

  wire dest_guard = has_guard(dest_sel);
  assign sif.raw = raw;
  assign sif.dest_guard = dest_guard;
  assign sif.sat_on = sat_enable;
  assign sif.int_op = is_int;

  // Destinations without guard bits keep the lower word of the datapath only
  wire [DW-1:0] next_data = dest_guard ? sif.value : {{GUARD_W{1'b0}}, sif.value[WW-1:0]};
  wire next_write = op_valid && legal && (op_code != dsaf_pkg::OP_COMPARE) &&
                    (!conditional || cond_pass);
  wire next_update = op_valid && legal && !conditional;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      result_valid <= dsaf_pkg::FLAG_RESET;
      result_dest <= dsaf_pkg::DEST_RESET;
      result_data <= {DW{1'b0}};
      illegal_operand <= dsaf_pkg::FLAG_RESET;
      flags_updated <= dsaf_pkg::FLAG_RESET;
    end else begin
      result_valid <= next_write;
      result_dest <= dest_sel;
      result_data <= next_data;
      illegal_operand <= op_valid && !legal;
      flags_updated <= next_update;
    end
  end

  // Flags hold through conditional and refused instructions
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      selected_condition_flag <= dsaf_pkg::FLAG_RESET;
      negative_flag <= dsaf_pkg::FLAG_RESET;
      zero_flag <= dsaf_pkg::FLAG_RESET;
      overflow_flag <= dsaf_pkg::FLAG_RESET;
      greater_flag <= dsaf_pkg::FLAG_RESET;
      range_exceed_term <= dsaf_pkg::FLAG_RESET;
    end else if (next_update) begin
      selected_condition_flag <= next_selected;
      negative_flag <= next_negative;
      zero_flag <= next_zero;
      overflow_flag <= next_overflow;
      greater_flag <= next_greater;
      range_exceed_term <= next_range;
    end
  end

  // Checking helpers: mode and forcing seen by the last flag update
  dsaf_pkg::dsaf_cs_t cs_seen;
  logic forced_seen;
  logic clamp_seen;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cs_seen <= dsaf_pkg::CS_CARRY;
      forced_seen <= dsaf_pkg::FLAG_RESET;
      clamp_seen <= dsaf_pkg::FLAG_RESET;
    end else begin
      cs_seen <= condition_select;
      forced_seen <= flag_forced;
      clamp_seen <= sif.clamped;
    end
  end
  wire mode_plain = flags_updated && !forced_seen;
  // Limits spelled out apart from the saturation unit, as they land in the register file
  wire [DW-1:0] wide_lim = raw[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
  wire [WW-1:0] word_lim = raw[DW] ? {1'b1, {(WW-1){1'b0}}} : {1'b0, {(WW-1){1'b1}}};
  wire [DW-1:0] sat_lim = dest_guard ? wide_lim : {{GUARD_W{1'b0}}, word_lim};
  wire [DW-1:0] sat_expect = is_int ? {sat_lim[DW-1:IL], {IL{1'b0}}} : sat_lim;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_bad_source;
    op_valid && op_known && needs_one && !src_one_ok(src_one_sel);
  endsequence

  sequence s_refused;
    illegal_operand && !result_valid && !flags_updated;
  endsequence

  sequence s_sat_request;
    op_valid && legal && !conditional && (op_code != dsaf_pkg::OP_COMPARE) && sat_enable && sif.range_hit;
  endsequence

  a_source_one_legal: assert property (s_bad_source |=> s_refused)
    else $error("bad source one was not refused");

  a_paired_dest_legal: assert property (op_valid && op_known && paired_mul && !paired_ok |=> s_refused)
    else $error("paired destination outside allowed set was not refused");

  a_carry_mode_word: assert property (mode_plain && cs_seen == dsaf_pkg::CS_CARRY && !overflow_flag
                                      && result_valid && !clamp_seen
                                      |-> selected_condition_flag == $past(carry_flag))
    else $error("carry mode flag differs from word carry");

  a_negative_mode_same: assert property (mode_plain && cs_seen == dsaf_pkg::CS_NEGATIVE
                                         |-> selected_condition_flag == negative_flag)
    else $error("negative mode flag differs from negative bit");

  a_zero_mode_same: assert property (mode_plain && cs_seen == dsaf_pkg::CS_ZERO
                                     |-> selected_condition_flag == zero_flag)
    else $error("zero mode flag differs from zero bit");

  a_overflow_mode_same: assert property (mode_plain && cs_seen == dsaf_pkg::CS_OVERFLOW
                                         |-> selected_condition_flag == overflow_flag)
    else $error("overflow mode flag differs from overflow bit");

  a_greater_mode_same: assert property (mode_plain && cs_seen == dsaf_pkg::CS_GREATER
                                        |-> selected_condition_flag == greater_flag)
    else $error("greater mode flag differs from greater bit");

  a_greater_eq_mode: assert property (mode_plain && cs_seen == dsaf_pkg::CS_GREATER_EQ
                                      |-> selected_condition_flag == !(negative_flag ^ range_exceed_term))
    else $error("greater-or-equal mode flag wrong");

  a_greater_equation: assert property (flags_updated
                                       |-> greater_flag == !((negative_flag ^ range_exceed_term) || zero_flag))
    else $error("greater bit does not follow its equation");

  a_conditional_flags_hold: assert property (op_valid && conditional ##1 1'b1
                                             |-> $stable(negative_flag) && $stable(zero_flag) &&
                                                 $stable(selected_condition_flag) && !flags_updated)
    else $error("conditional instruction changed the flags");

  a_saturate_limit: assert property (s_sat_request |=> result_valid && clamp_seen &&
                                     (result_data == $past(sat_expect)))
    else $error("saturated result not written");

  a_integer_low_clear: assert property (op_valid && legal && is_int && (!conditional || cond_pass)
                                        |=> result_valid && result_data[IL-1:0] == {IL{1'b0}})
    else $error("integer result lower word not clear");

  a_forced_carry_mode: assert property (flags_updated && forced_seen
                                        |-> selected_condition_flag == $past(carry_flag))
    else $error("forced flag differs from word carry or borrow");

  a_compare_no_write: assert property (op_valid && op_code == dsaf_pkg::OP_COMPARE |=> !result_valid)
    else $error("compare wrote a result");

  a_unknown_op_refused: assert property (op_valid && !op_known |=> s_refused)
    else $error("unknown opcode was not refused");
endmodule
`default_nettype wire

/* core/dsaf_pkg.sv */
// Shared constants and types for the DSP ALU arithmetic and flag block
package dsaf_pkg;
  localparam int WORD_W = 32;
  localparam int GUARD_W = 8;
  localparam int INT_LSB = 16;

  typedef logic [2:0] dsaf_reg_t;
  localparam dsaf_reg_t REG_FIRST_X = 3'h0;
  localparam dsaf_reg_t REG_SECOND_X = 3'h1;
  localparam dsaf_reg_t REG_FIRST_Y = 3'h2;
  localparam dsaf_reg_t REG_SECOND_Y = 3'h3;
  localparam dsaf_reg_t REG_FIRST_M = 3'h4;
  localparam dsaf_reg_t REG_SECOND_M = 3'h5;
  localparam dsaf_reg_t REG_FIRST_ACC = 3'h6;
  localparam dsaf_reg_t REG_SECOND_ACC = 3'h7;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUBTRACT = 4'h1,
    OP_ADD_CARRY = 4'h2,
    OP_SUB_BORROW = 4'h3,
    OP_COMPARE = 4'h4,
    OP_COPY = 4'h5,
    OP_ABS = 4'h6,
    OP_NEGATE = 4'h7,
    OP_CLEAR = 4'h8,
    OP_INCREMENT = 4'h9,
    OP_DECREMENT = 4'ha
  } dsaf_op_t;

  typedef logic [2:0] dsaf_cs_t;
  localparam dsaf_cs_t CS_CARRY = 3'h0;
  localparam dsaf_cs_t CS_NEGATIVE = 3'h1;
  localparam dsaf_cs_t CS_ZERO = 3'h2;
  localparam dsaf_cs_t CS_OVERFLOW = 3'h3;
  localparam dsaf_cs_t CS_GREATER = 3'h4;
  localparam dsaf_cs_t CS_GREATER_EQ = 3'h5;

  localparam logic FLAG_RESET = 1'b0;
  localparam dsaf_reg_t DEST_RESET = 3'h0;
endpackage

/* core/dsaf_sat_if.sv */
// Carrier between the arithmetic core and its saturation unit
`timescale 1ns/100ps
`default_nettype none
interface dsaf_sat_if #(
  parameter int DW = 40
);
  logic [DW:0] raw;
  logic dest_guard;
  logic sat_on;
  logic int_op;
  logic [DW-1:0] value;
  logic range_hit;
  logic clamped;

  modport core (output raw, output dest_guard, output sat_on, output int_op,
                input value, input range_hit, input clamped);
  modport unit (input raw, input dest_guard, input sat_on, input int_op,
                output value, output range_hit, output clamped);
endinterface
`default_nettype wire

/* core/dsaf_sat_unit.sv */
// Destination range check and saturation of the extended ALU result
`timescale 1ns/100ps
`default_nettype none
module dsaf_sat_unit #(
  parameter int GUARD_W = dsaf_pkg::GUARD_W
) (
  dsaf_sat_if.unit sif // Raw result in, stored value out
);
  localparam int WW = dsaf_pkg::WORD_W;
  localparam int DW = WW + GUARD_W;
  localparam int IL = dsaf_pkg::INT_LSB;

  // Raw is one bit wider than the datapath, so its top bit is the true sign
  wire ovf_wide = sif.raw[DW] != sif.raw[DW-1];
  wire [GUARD_W+1:0] word_top = sif.raw[DW:WW-1];
  wire ovf_word = !((&word_top) || !(|word_top));
  wire [DW-1:0] pos_max = sif.dest_guard ? {1'b0, {(DW-1){1'b1}}}
                                         : {{(GUARD_W+1){1'b0}}, {(WW-1){1'b1}}};
  wire [DW-1:0] neg_min = ~pos_max;
  wire [DW-1:0] limit = sif.raw[DW] ? neg_min : pos_max;
  // Integer results keep the lower word clear even when clamped
  wire [DW-1:0] int_mask = {{(DW-IL){1'b1}}, {IL{1'b0}}};
  wire [DW-1:0] limit_m = sif.int_op ? (limit & int_mask) : limit;

  assign sif.range_hit = sif.dest_guard ? ovf_wide : ovf_word;
  assign sif.clamped = sif.sat_on && sif.range_hit;
  assign sif.value = sif.clamped ? limit_m : sif.raw[DW-1:0];
endmodule
`default_nettype wire

/* testbench/dsaf_alu_bench.sv */
// Self-checking bench for the DSP ALU arithmetic and flag block
`timescale 1ns/100ps
`default_nettype none
module dsaf_alu_bench;
  logic sys_clk, resetn, op_valid, use_src_two, paired_mul, conditional, cond_pass, sat_enable, load_en;
  dsaf_pkg::dsaf_op_t op_code;
  dsaf_pkg::dsaf_reg_t src_one_sel, src_two_sel, dest_sel, result_dest, load_sel;
  dsaf_pkg::dsaf_cs_t condition_select;
  logic [39:0] src_one_data, src_two_data, result_data, load_val;
  logic result_valid, illegal_operand, flags_updated, selected_condition_flag, negative_flag, zero_flag;
  logic overflow_flag, greater_flag, range_exceed_term;
  int err_count, checks_done;

  dsaf_alu dut (.sys_clk, .resetn, .op_valid, .op_code, .use_src_two, .paired_mul, .conditional, .cond_pass,
    .src_one_sel, .src_two_sel, .dest_sel, .src_one_data, .src_two_data, .condition_select, .sat_enable,
    .result_valid, .result_dest, .result_data, .illegal_operand, .flags_updated, .selected_condition_flag,
    .negative_flag, .zero_flag, .overflow_flag, .greater_flag, .range_exceed_term);

  dsaf_regfile_model rf (.sys_clk, .resetn, .load_en, .load_sel, .load_val, .wr_en(result_valid),
    .wr_sel(result_dest), .wr_val(result_data), .rd_one_sel(src_one_sel), .rd_two_sel(src_two_sel),
    .rd_one_val(src_one_data), .rd_two_val(src_two_data));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic fail(input string msg);
    err_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk_data(input logic [39:0] exp);
    checks_done++;
    if (result_data !== exp) fail($sformatf("data %h, expected %h", result_data, exp));
  endtask

  // Strobes, destination, then selected, N, Z, V, greater and range bits
  task automatic chk_state(input logic [11:0] exp);
    logic [11:0] got;
    got = {result_valid, illegal_operand, flags_updated, result_dest, selected_condition_flag, negative_flag,
      zero_flag, overflow_flag, greater_flag, range_exceed_term};
    checks_done++;
    if (got !== exp) fail($sformatf("state %b, expected %b", got, exp));
  endtask

  // Register index: 0/1 X, 2/3 Y, 4/5 M, 6/7 accumulators
  // Mods are use_src_two, paired_mul, conditional, cond_pass; outputs land one edge later
  task automatic issue(input dsaf_pkg::dsaf_op_t op, input dsaf_pkg::dsaf_reg_t s1, input dsaf_pkg::dsaf_reg_t s2,
      input dsaf_pkg::dsaf_reg_t d, input dsaf_pkg::dsaf_cs_t cs, input logic sat, input logic [3:0] mods);
    op_valid = 1'b1;
    op_code = op;
    {src_one_sel, src_two_sel, dest_sel, condition_select, sat_enable} = {s1, s2, d, cs, sat};
    {use_src_two, paired_mul, conditional, cond_pass} = mods;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic idle();
    op_valid = 1'b0;
    load_en = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic ld(input dsaf_pkg::dsaf_reg_t s, input logic [39:0] v);
    {load_en, load_sel, load_val} = {1'b1, s, v};
    @(posedge sys_clk);
    #1;
  endtask

  task automatic test_end(input string name);
    $display("Test %s finished, mismatches so far %0d", name, err_count);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fail("run exceeded its time limit");
    conclude();
  end

  initial begin
    {resetn, op_valid, use_src_two, paired_mul, conditional, cond_pass, sat_enable, load_en} = 8'h00;
    {src_one_sel, src_two_sel, dest_sel, load_sel, condition_select} = 15'h0000;
    op_code = dsaf_pkg::OP_ADD;
    load_val = 40'h00_0000_0000;
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk_state({3'h0, 3'h0, 6'h00});
    test_end("reset");
    ld(3'h0, 40'h00_FFFF_FFFF);
    ld(3'h1, 40'h00_0000_0000);
    ld(3'h2, 40'h00_0000_0001);
    ld(3'h3, 40'h00_8000_5678);
    ld(3'h4, 40'h00_7FFF_1234);
    ld(3'h7, 40'h00_7FFF_FFFF);
    idle();
    // Minus one plus one: carry out of bit 31, zero result
    issue(dsaf_pkg::OP_ADD, 3'h0, 3'h2, 3'h6, 3'h0, 1'b0, 4'h0);
    chk_data(40'h00_0000_0000);
    chk_state({3'h5, 3'h6, 6'h28});
    // Every select mode back to back, reserved ones read zero
    for (int cs = 0; cs < 8; cs++) begin
      issue(dsaf_pkg::OP_ADD, 3'h7, 3'h2, 3'h6, 3'(cs), 1'b0, 4'h0);
      chk_data(40'h00_8000_0000);
      chk_state({3'h5, 3'h6, 8'h38 >> cs & 8'h01 ? 1'b1 : 1'b0, 5'h06});
    end
    test_end("select modes");
    issue(dsaf_pkg::OP_ADD, 3'h7, 3'h2, 3'h5, 3'h4, 1'b0, 4'h0);
    chk_data(40'h00_8000_0000);
    chk_state({3'h5, 3'h5, 6'h05});
    issue(dsaf_pkg::OP_ADD, 3'h7, 3'h2, 3'h5, 3'h4, 1'b1, 4'h0);
    chk_data(40'h00_7FFF_FFFF);
    issue(dsaf_pkg::OP_ADD, 3'h7, 3'h2, 3'h6, 3'h4, 1'b1, 4'h0);
    chk_data(40'h00_8000_0000);
    chk_state({3'h5, 3'h6, 6'h26});
    // Zero minus one in zero mode still reports the borrow
    issue(dsaf_pkg::OP_SUBTRACT, 3'h1, 3'h2, 3'h7, 3'h2, 1'b0, 4'h0);
    chk_data(40'hFF_FFFF_FFFF);
    chk_state({3'h5, 3'h7, 6'h30});
    test_end("range and saturation");
    issue(dsaf_pkg::OP_INCREMENT, 3'h0, 3'h4, 3'h5, 3'h3, 1'b0, 4'h8);
    chk_data(40'h00_8000_0000);
    chk_state({3'h5, 3'h5, 6'h25});
    issue(dsaf_pkg::OP_INCREMENT, 3'h0, 3'h4, 3'h5, 3'h3, 1'b1, 4'h8);
    chk_data(40'h00_7FFF_0000);
    issue(dsaf_pkg::OP_DECREMENT, 3'h0, 3'h3, 3'h7, 3'h1, 1'b1, 4'h8);
    chk_data(40'hFF_7FFF_0000);
    chk_state({3'h5, 3'h7, 6'h34});
    test_end("integer");
    issue(dsaf_pkg::OP_ADD, 3'h2, 3'h2, 3'h6, 3'h0, 1'b0, 4'h0);
    chk_state({3'h2, 3'h6, 6'h34});
    issue(dsaf_pkg::OP_ADD, 3'h0, 3'h0, 3'h6, 3'h0, 1'b0, 4'h0);
    chk_state({3'h2, 3'h6, 6'h34});
    issue(dsaf_pkg::OP_ADD, 3'h0, 3'h2, 3'h1, 3'h0, 1'b0, 4'h4);
    chk_state({3'h2, 3'h1, 6'h34});
    issue(dsaf_pkg::dsaf_op_t'(4'hb), 3'h0, 3'h2, 3'h6, 3'h0, 1'b0, 4'h0);
    chk_state({3'h2, 3'h6, 6'h34});
    issue(dsaf_pkg::OP_ADD, 3'h1, 3'h2, 3'h7, 3'h0, 1'b0, 4'h4);
    chk_data(40'h00_0000_0001);
    chk_state({3'h5, 3'h7, 6'h02});
    test_end("operand legality");
    issue(dsaf_pkg::OP_ADD, 3'h0, 3'h2, 3'h6, 3'h0, 1'b0, 4'h3);
    chk_state({3'h4, 3'h6, 6'h02});
    issue(dsaf_pkg::OP_ADD, 3'h0, 3'h2, 3'h6, 3'h0, 1'b0, 4'h2);
    chk_state({3'h0, 3'h6, 6'h02});
    issue(dsaf_pkg::OP_ADD, 3'h0, 3'h2, 3'h6, 3'h0, 1'b0, 4'h0);
    chk_state({3'h5, 3'h6, 6'h28});
    idle();
    test_end("conditional");
    // Stored carry feeds the chained add; compare never writes; clamp below the word range
    issue(dsaf_pkg::OP_ADD_CARRY, 3'h1, 3'h2, 3'h7, 3'h4, 1'b0, 4'h0);
    chk_data(40'h00_0000_0002);
    chk_state({3'h5, 3'h7, 6'h02});
    issue(dsaf_pkg::OP_COMPARE, 3'h0, 3'h2, 3'h6, 3'h5, 1'b0, 4'h0);
    chk_state({3'h1, 3'h6, 6'h10});
    issue(dsaf_pkg::OP_DECREMENT, 3'h0, 3'h3, 3'h5, 3'h0, 1'b1, 4'h8);
    chk_data(40'h00_8000_0000);
    chk_state({3'h5, 3'h5, 6'h17});
    idle();
    test_end("chained and compare");
    conclude();
  end
endmodule
`default_nettype wire

/* testbench/dsaf_regfile_model.sv */
// Register file model that feeds the ALU sources and takes its writes
`timescale 1ns/100ps
`default_nettype none
module dsaf_regfile_model (
  input wire logic sys_clk, // Core clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic load_en, // Preload strobe from the bench
  input wire dsaf_pkg::dsaf_reg_t load_sel, // Preload register
  input wire logic [39:0] load_val, // Preload value
  input wire logic wr_en, // Write strobe from the ALU
  input wire dsaf_pkg::dsaf_reg_t wr_sel, // Written register
  input wire logic [39:0] wr_val, // Written value
  input wire dsaf_pkg::dsaf_reg_t rd_one_sel, // Source one index
  input wire dsaf_pkg::dsaf_reg_t rd_two_sel, // Source two index
  output logic [39:0] rd_one_val, // Source one contents
  output logic [39:0] rd_two_val // Source two contents
);
  logic [39:0] regs [8];

  // No guard lanes here: show the wrong sign so only true extension passes
  function automatic logic [39:0] view(input dsaf_pkg::dsaf_reg_t sel, input logic [39:0] v);
    view = (sel >= dsaf_pkg::REG_FIRST_ACC) ? v : {{8{~v[31]}}, v[31:0]};
  endfunction

  assign rd_one_val = view(rd_one_sel, regs[rd_one_sel]);
  assign rd_two_val = view(rd_two_sel, regs[rd_two_sel]);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= 40'h00_0000_0000;
      end
    end else if (load_en) begin
      regs[load_sel] <= load_val;
    end else if (wr_en) begin
      regs[wr_sel] <= wr_val;
    end
  end
endmodule
`default_nettype wire
